// ### hdl/css_pin_if.sv
// Purpose: Carries raw pin levels to the synchroniser and synced levels back
// Assumes: One clock domain on the synced side
// Notes:   Width set by the user of the interface
`timescale 1ns/100ps
interface css_pin_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport drv (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// ### hdl/css_pkg.sv
// Purpose: Shared constants and types for the configuration status signalling block
// Assumes: 50 MHz system clock
// Notes:   Pin synchroniser carries the status line and the three mode inputs
package css_pkg;

  localparam int          CLK_MHZ        = 50;
  // Shortest master wait is used; the longest allowed wait is 300 us
  localparam int          DLY_MIN_US     = 30;
  localparam int          CNT_W          = 11;
  localparam logic [10:0] DLY_CYC        = 11'(DLY_MIN_US * CLK_MHZ);
  localparam logic [10:0] CNT_ZERO       = 11'h000;
  localparam logic [10:0] CNT_ONE        = 11'h001;

  localparam int          MODE_W         = 3;
  localparam int          SYNC_W         = 4;
  localparam int          SYNC_INIT_BIT  = 3;
  localparam int          MODE_MASTER_BIT = 0;
  localparam logic        MASTER_LEVEL   = 1'b0;
  localparam logic [2:0]  MODE_RST       = 3'h0;

  typedef enum logic [4:0] {
    ST_CLEAR  = 5'h01,
    ST_WAIT   = 5'h02,
    ST_DELAY  = 5'h04,
    ST_CONFIG = 5'h08,
    ST_USER   = 5'h10
  } css_state_t;

  typedef struct packed {
    css_state_t  st;
    logic [10:0] cnt;
    logic [2:0]  mode;
    logic        err;
    logic        start;
    logic        hi;
    logic        hi_oe;
    logic        lo;
    logic        lo_oe;
    logic        init;
    logic        init_oe;
  } css_top_t;

  localparam css_top_t TOP_RST = '{st: ST_CLEAR, cnt: CNT_ZERO, mode: MODE_RST, err: 1'b0,
                                   start: 1'b0, hi: 1'b1, hi_oe: 1'b1, lo: 1'b0, lo_oe: 1'b1,
                                   init: 1'b0, init_oe: 1'b1};

endpackage

// ### hdl/css_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs
// Assumes: Pins are not related to clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module css_sync #(
  parameter int W = 4
) (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  css_pin_if.snk      pins
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } css_sync_t;

  css_sync_t r;
  css_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = pins.raw;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pins.synced = r.s2;

endmodule

// ### hdl/css_top.sv
// Purpose: Configuration status pins: pending outputs and the open-drain init line
// Assumes: Power, clearing, error and io-active indications come from logic on clk_in
// Notes:   Pin outputs are registered, so user pass-through lags one cycle
`timescale 1ns/100ps

// How it works
// - High pending pin driven high until active
// - Low pending pin driven low until active
// - Init line only pulled low or released until active
// - Init held low during power-up and clearing
// - Outside low on init keeps device waiting
// - Master modes wait extra 30 us (1500 cycles)
// - Init pulled low on configuration data error
// - Init becomes user pin once active
// - Mode inputs sampled when init goes high
module css_top (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       pwr_stable_in,
  input  wire logic       clear_busy_in,
  input  wire logic       cfg_error_in,
  input  wire logic       io_active_in,
  input  wire logic [2:0] cfg_mode_select_in,
  input  wire logic       init_n_in,
  input  wire logic       user_hi_in,
  input  wire logic       user_hi_oe_in,
  input  wire logic       user_lo_in,
  input  wire logic       user_lo_oe_in,
  input  wire logic       user_init_in,
  input  wire logic       user_init_oe_in,
  output logic            cfg_pending_hi_out,
  output logic            cfg_pending_hi_oe_out,
  output logic            cfg_pending_lo_n_out,
  output logic            cfg_pending_lo_n_oe_out,
  output logic            init_n_out,
  output logic            init_n_oe_out,
  output logic [2:0]      cfg_mode_out,
  output logic            cfg_start_out,
  output logic            cfg_running_out
);

  css_pin_if #(.W(css_pkg::SYNC_W)) pins ();

  css_pkg::css_top_t r;
  css_pkg::css_top_t next_r;
  css_pkg::css_state_t nst;
  logic              init_s;
  logic [2:0]        mode_s;
  logic              master;

  assign pins.raw = {init_n_in, cfg_mode_select_in};
  assign init_s   = pins.synced[css_pkg::SYNC_INIT_BIT];
  assign mode_s   = pins.synced[css_pkg::MODE_W-1:0];
  assign master   = (mode_s[css_pkg::MODE_MASTER_BIT] == css_pkg::MASTER_LEVEL);

  css_sync #(.W(css_pkg::SYNC_W)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .pins   (pins)
  );

  always_comb begin
    next_r       = r;
    next_r.start = 1'b0;
    nst          = r.st;
    unique case (r.st)
      css_pkg::ST_CLEAR: begin
        if (pwr_stable_in && !clear_busy_in) begin
          nst = css_pkg::ST_WAIT;
        end
      end
      css_pkg::ST_WAIT: begin
        if (init_s) begin
          next_r.mode = mode_s;
          if (master) begin
            nst        = css_pkg::ST_DELAY;
            next_r.cnt = css_pkg::DLY_CYC - css_pkg::CNT_ONE;
          end else begin
            nst          = css_pkg::ST_CONFIG;
            next_r.start = 1'b1;
          end
        end
      end
      css_pkg::ST_DELAY: begin
        if (r.cnt == css_pkg::CNT_ZERO) begin
          nst          = css_pkg::ST_CONFIG;
          next_r.start = 1'b1;
        end else begin
          next_r.cnt = r.cnt - css_pkg::CNT_ONE;
        end
      end
      css_pkg::ST_CONFIG: begin
        if (cfg_error_in) begin
          next_r.err = 1'b1;
        end
        if (io_active_in) begin
          nst = css_pkg::ST_USER;
        end
      end
      css_pkg::ST_USER: begin
        nst = css_pkg::ST_USER;
      end
    endcase
    next_r.st = nst;

    if (nst == css_pkg::ST_USER) begin
      next_r.hi      = user_hi_in;
      next_r.hi_oe   = user_hi_oe_in;
      next_r.lo      = user_lo_in;
      next_r.lo_oe   = user_lo_oe_in;
      next_r.init    = user_init_in;
      next_r.init_oe = user_init_oe_in;
    end else begin
      next_r.hi      = 1'b1;
      next_r.hi_oe   = 1'b1;
      next_r.lo      = 1'b0;
      next_r.lo_oe   = 1'b1;
      next_r.init    = 1'b0;
      next_r.init_oe = (nst == css_pkg::ST_CLEAR) || (nst == css_pkg::ST_CONFIG && next_r.err);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= css_pkg::TOP_RST;
    end else begin
      r <= next_r;
    end
  end

  assign cfg_pending_hi_out      = r.hi;
  assign cfg_pending_hi_oe_out   = r.hi_oe;
  assign cfg_pending_lo_n_out    = r.lo;
  assign cfg_pending_lo_n_oe_out = r.lo_oe;
  assign init_n_out              = r.init;
  assign init_n_oe_out           = r.init_oe;
  assign cfg_mode_out            = r.mode;
  assign cfg_start_out           = r.start;
  assign cfg_running_out         = (r.st == css_pkg::ST_CONFIG);

  property p_hi_pending;
    @(posedge clk_in) disable iff (rst_in)
    (r.st != css_pkg::ST_USER) |-> (cfg_pending_hi_out && cfg_pending_hi_oe_out);
  endproperty
  a_hi_pending: assert property (p_hi_pending) else $error("high pending pin not high");

  property p_lo_pending;
    @(posedge clk_in) disable iff (rst_in)
    (r.st != css_pkg::ST_USER) |-> (!cfg_pending_lo_n_out && cfg_pending_lo_n_oe_out);
  endproperty
  a_lo_pending: assert property (p_lo_pending) else $error("low pending pin not low");

  property p_open_drain;
    @(posedge clk_in) disable iff (rst_in)
    (r.st != css_pkg::ST_USER) |-> !init_n_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("init driven high");

  property p_clear_low;
    @(posedge clk_in) disable iff (rst_in)
    (r.st != css_pkg::ST_USER && !pwr_stable_in) |=> init_n_oe_out;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("init released during power up");

  property p_hold_wait;
    @(posedge clk_in) disable iff (rst_in)
    (r.st == css_pkg::ST_WAIT && !init_s) |=> (r.st == css_pkg::ST_WAIT);
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("left wait with init low");

  property p_delay_load;
    @(posedge clk_in) disable iff (rst_in)
    (r.st == css_pkg::ST_WAIT && init_s && master) |=> (r.st == css_pkg::ST_DELAY && r.cnt == css_pkg::DLY_CYC - css_pkg::CNT_ONE);
  endproperty
  a_delay_load: assert property (p_delay_load) else $error("master delay not loaded");

  property p_delay_end;
    @(posedge clk_in) disable iff (rst_in)
    (r.st == css_pkg::ST_DELAY && r.cnt != css_pkg::CNT_ZERO) |=> (r.st == css_pkg::ST_DELAY && !cfg_start_out);
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("master delay cut short");

  property p_error_low;
    @(posedge clk_in) disable iff (rst_in)
    (r.st == css_pkg::ST_CONFIG && cfg_error_in && !io_active_in) |=>
      init_n_oe_out ##1 (init_n_oe_out || r.st == css_pkg::ST_USER);
  endproperty
  a_error_low: assert property (p_error_low) else $error("error not shown on init");

  property p_user_init;
    @(posedge clk_in) disable iff (rst_in)
    (r.st == css_pkg::ST_USER) |=> (init_n_out == $past(user_init_in) && init_n_oe_out == $past(user_init_oe_in));
  endproperty
  a_user_init: assert property (p_user_init) else $error("init not a user pin");

  property p_mode_sample;
    @(posedge clk_in) disable iff (rst_in)
    (r.st == css_pkg::ST_WAIT ##1 r.st != css_pkg::ST_WAIT) |-> (cfg_mode_out == $past(mode_s) && $past(init_s));
  endproperty
  a_mode_sample: assert property (p_mode_sample) else $error("mode not sampled on init high");

  property p_exit_high;
    @(posedge clk_in) disable iff (rst_in)
    $rose(cfg_start_out) |-> ($past(init_s) || $past(r.st) == css_pkg::ST_DELAY);
  endproperty
  a_exit_high: assert property (p_exit_high) else $error("start without init high");

endmodule

// ### tb/config_status_signalling_tb_top.sv
// Purpose: Scenario bench for the configuration status pins
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Master wait is checked against the full allowed window
`timescale 1ns/100ps
module config_status_signalling_tb_top;
  logic       clk_in, rst_in, pwr, clr, err, act, hold;
  logic [2:0] mode_drv, mode_pins, mode_out;
  logic [5:0] user_v;
  logic       init_wire, hi, hi_oe, lo, lo_oe, init_n, init_oe, start, running;
  int         bad_count, n_tests, cyc, n;

  css_host_model host_u (.init_oe_in(init_oe), .init_val_in(init_n), .hold_low_in(hold), .mode_in(mode_drv),
                         .init_wire_out(init_wire), .mode_pins_out(mode_pins));
  css_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .pwr_stable_in(pwr), .clear_busy_in(clr),
    .cfg_error_in(err), .io_active_in(act), .cfg_mode_select_in(mode_pins), .init_n_in(init_wire),
    .user_hi_in(user_v[5]), .user_hi_oe_in(user_v[4]), .user_lo_in(user_v[3]), .user_lo_oe_in(user_v[2]),
    .user_init_in(user_v[1]), .user_init_oe_in(user_v[0]), .cfg_pending_hi_out(hi),
    .cfg_pending_hi_oe_out(hi_oe), .cfg_pending_lo_n_out(lo), .cfg_pending_lo_n_oe_out(lo_oe),
    .init_n_out(init_n), .init_n_oe_out(init_oe), .cfg_mode_out(mode_out), .cfg_start_out(start),
    .cfg_running_out(running));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset(input logic p, input logic c, input logic h, input logic [2:0] m);
    rst_in = 1'b1;
    pwr = p;
    clr = c;
    hold = h;
    mode_drv = m;
    step(4);
    rst_in = 1'b0;
  endtask

  // Start pulse is one cycle, so it is looked at every cycle
  task automatic wait_start();
    n = 0;
    while (start !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
  endtask

  task automatic t_clear();
    do_reset(1'b0, 1'b1, 1'b0, 3'h5);
    step(3);
    chk({hi, hi_oe, lo, lo_oe, init_n, init_oe}, 16'h0035);
    pwr = 1'b1;
    step(3);
    chk(init_oe, 1'b1);
    hold = 1'b1;
    clr = 1'b0;
    step(1);
    chk(init_oe, 1'b0);
  endtask

  // Errors in the wait state must not pull the line
  task automatic t_hold();
    err = 1'b1;
    step(20);
    chk({running, start, init_oe}, 16'h0000);
    err = 1'b0;
    hold = 1'b0;
    wait_start();
    chk(16'(n >= 1 && n <= 4), 16'h0001);
    chk(mode_out, 3'h5);
    chk(running, 1'b1);
    mode_drv = 3'h2;
    step(3);
    chk(mode_out, 3'h5);
    chk(start, 1'b0);
  endtask

  task automatic t_error();
    err = 1'b1;
    step(1);
    err = 1'b0;
    chk({init_oe, init_n}, 16'h0002);
    step(5);
    chk({init_oe, init_n, init_wire}, 16'h0004);
  endtask

  task automatic t_user();
    user_v = 6'h1b;
    act = 1'b1;
    step(1);
    act = 1'b0;
    step(2);
    chk({hi, hi_oe, lo, lo_oe, init_n, init_oe}, 16'h001b);
    chk(running, 1'b0);
    user_v = 6'h24;
    step(2);
    chk({hi, hi_oe, lo, lo_oe, init_n, init_oe}, 16'h0024);
  endtask

  // Full window is 30 to 300 us at 50 cycles per us, plus sync lag
  task automatic t_master();
    do_reset(1'b1, 1'b0, 1'b1, 3'h6);
    step(5);
    hold = 1'b0;
    wait_start();
    chk(16'(n >= 1500 && n <= 15003), 16'h0001);
    chk(mode_out, 3'h6);
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc >= 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    rst_in = 1'b1;
    pwr = 1'b0;
    clr = 1'b1;
    err = 1'b0;
    act = 1'b0;
    hold = 1'b0;
    mode_drv = 3'h5;
    user_v = 6'h00;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    t_clear();
    t_hold();
    t_error();
    t_user();
    t_master();
    end_of_test();
  end
endmodule

// ### tb/css_host_model.sv
// Purpose: Outside controller on the init line and the mode pins
// Assumes: Wire has a pull-up; any party pulling low wins
// Notes:   Mode pins follow mode_in directly; the bench changes them during a run
`timescale 1ns/100ps
module css_host_model (
  input  wire logic       init_oe_in,
  input  wire logic       init_val_in,
  input  wire logic       hold_low_in,
  input  wire logic [2:0] mode_in,
  output logic            init_wire_out,
  output logic [2:0]      mode_pins_out
);
  assign init_wire_out = hold_low_in ? 1'b0 : (init_oe_in ? init_val_in : 1'b1);
  assign mode_pins_out = mode_in;
endmodule
